// file: hdl/ccc_charge_ctrl.sv
// charge cycle controller top
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_charge_ctrl #(
  parameter bit EXT_TEMP_ZONES = 1'b1,
  parameter int unsigned TICK_CYC = `CCC_TICK_US * `CCC_CLK_MHZ,
  parameter int unsigned MIN_TICKS = `CCC_US_PER_MIN / `CCC_TICK_US,
  parameter int unsigned PRE_TICKS = `CCC_PRECHG_MIN * MIN_TICKS,
  parameter int unsigned FAST_TICKS = `CCC_FAST_HR * `CCC_MIN_PER_HR * MIN_TICKS,
  parameter int unsigned RAISE_TICKS = `CCC_RAISE_MIN * MIN_TICKS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic input_present_in,
  input wire logic input_headroom_in,
  input wire logic limit_sel_low_in,
  input wire logic limit_sel_high_in,
  input wire logic current_set_short_in,
  input wire logic out_current_min_in,
  input wire logic precharge_term_set_float_in,
  input wire logic [`CCC_PCT_W-1:0] term_pct_in,
  input wire logic batt_above_exit_level_in,
  input wire logic batt_above_recharge_in,
  input wire logic taper_done_in,
  input wire logic batt_present_in,
  input wire logic ts_disable_in,
  input wire logic ts_term_timer_disable_mode_in,
  input wire logic ts_cold_in,
  input wire logic ts_cool_in,
  input wire logic ts_warm_in,
  input wire logic ts_hot_in,
  input wire logic thermal_reg_in,
  input wire logic input_voltage_power_mgmt_in,
  input wire logic usb_limit_in,
  output logic charge_enable_out,
  output logic precharge_out,
  output logic half_current_out,
  output logic reduced_vreg_out,
  output logic term_enable_out,
  output logic term_raise_out,
  output logic [`CCC_PCT_W-1:0] term_pct_out,
  output logic [`CCC_PCT_W:0] precharge_pct_out,
  output ccc_pkg::ccc_ilim_e ilim_mode_out,
  output logic [`CCC_MA_W-1:0] ilim_ma_out,
  output logic batt_detect_out,
  output logic timer_expired_out,
  output logic current_set_fault_out,
  output logic charge_status_n_oe_out,
  output logic power_good_n_oe_out
);
  import ccc_pkg::*;

  // ****************************************************
  // state record
  // ****************************************************

  typedef struct packed {
    ccc_state_e st;
    logic det_after_taper;
    logic status_on;
    logic current_set_latch;
    logic term_timer_disable_mode_seen;
    logic expired;
    logic chg_en;
    logic prechg;
    logic half_cur;
    logic low_vreg;
    logic term_en;
    logic raise;
    logic det_run;
    logic stat_oe;
    logic pg_oe;
    ccc_ilim_e ilim;
    logic [`CCC_MA_W-1:0] ilim_ma;
    logic [`CCC_PCT_W-1:0] term_pct;
    logic [`CCC_PCT_W:0] pre_pct;
  } ccc_ctrl_s;

  ccc_ctrl_s s_ff;
  ccc_ctrl_s nxt_s;

  logic fault;
  logic active;
  logic run;
  logic trip;
  logic term_timer_disable_mode_rise;
  logic term_timer_disable_mode_fall;
  logic go;
  logic pre_exp;
  logic fast_exp;
  logic raise_exp;
  logic slowed;
  ccc_state_e start_st;

  // ****************************************************
  // decoders
  // ****************************************************

  // temperature outside the charging window
  function automatic logic temp_fault(input logic cold, input logic warm,
                                      input logic hot);
    temp_fault = cold || hot || (!EXT_TEMP_ZONES && warm); // see RL7 see RL8
  endfunction

  // states in which current flows into the output
  function automatic logic charging(input ccc_state_e st);
    charging = (st == ST_PRECHG) || (st == ST_FAST) || (st == ST_TERM_TIMER_DISABLE_MODE);
  endfunction

  // three-level limit pin
  function automatic ccc_ilim_e ilim_decode(input logic lo, input logic hi);
    if (lo) begin
      ilim_decode = ILIM_CURRENT_SET;
    end else if (hi) begin
      ilim_decode = ILIM_HIGH;
    end else begin
      ilim_decode = ILIM_LOW;
    end
  endfunction

  // ****************************************************
  // conditions
  // ****************************************************

  // comparator bits arrive already synchronous, see RL26
  assign fault = temp_fault(ts_cold_in, ts_warm_in, ts_hot_in);
  assign active = input_present_in && input_headroom_in && !ts_disable_in
                  && !s_ff.current_set_latch;
  assign run = active && !fault;
  assign trip = current_set_short_in && out_current_min_in && s_ff.chg_en;
  assign term_timer_disable_mode_rise = ts_term_timer_disable_mode_in && !s_ff.term_timer_disable_mode_seen;
  assign term_timer_disable_mode_fall = !ts_term_timer_disable_mode_in && s_ff.term_timer_disable_mode_seen;
  assign go = run && !trip && !term_timer_disable_mode_rise && !term_timer_disable_mode_fall;
  assign start_st = batt_above_exit_level_in ? ST_FAST : ST_PRECHG;
  assign slowed = thermal_reg_in || input_voltage_power_mgmt_in || usb_limit_in;

  // ****************************************************
  // timers
  // ****************************************************

  // leaving a timed state clears its timer, see RL16
  ccc_timer #(
    .PRESC_CYC(TICK_CYC),
    .LIMIT(PRE_TICKS)
  ) u_pre_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(s_ff.st != ST_PRECHG),
    .run_in(run),
    .half_in(1'b0),
    .expired_out(pre_exp)
  );

  // held clear in disable mode, paused on low headroom, see RL10 see RL24
  ccc_timer #(
    .PRESC_CYC(TICK_CYC),
    .LIMIT(FAST_TICKS)
  ) u_fast_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(s_ff.st != ST_FAST),
    .run_in(run),
    .half_in(slowed),
    .expired_out(fast_exp)
  );

  // first minute of each charge cycle
  ccc_timer #(
    .PRESC_CYC(TICK_CYC),
    .LIMIT(RAISE_TICKS)
  ) u_raise_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(!charging(s_ff.st)),
    .run_in(run),
    .half_in(1'b0),
    .expired_out(raise_exp)
  );

  // ****************************************************
  // next state
  // ****************************************************

  always_comb begin
    nxt_s = s_ff;
    nxt_s.term_timer_disable_mode_seen = ts_term_timer_disable_mode_in;
    if (!input_present_in) begin
      // power removed: the next power-up is a fresh first charge
      nxt_s.st = ST_IDLE;
      nxt_s.current_set_latch = 1'b0; // see RL2
      nxt_s.status_on = 1'b1;
      nxt_s.expired = 1'b0;
      nxt_s.term_timer_disable_mode_seen = 1'b0;
    end else if (trip || s_ff.current_set_latch) begin
      nxt_s.current_set_latch = 1'b1; // see RL2
      nxt_s.st = ST_IDLE;
      nxt_s.term_timer_disable_mode_seen = 1'b0;
    end else if (ts_disable_in) begin
      nxt_s.st = ST_IDLE; // see RL9
      nxt_s.status_on = 1'b1;
      nxt_s.expired = 1'b0;
      nxt_s.term_timer_disable_mode_seen = 1'b0;
    end else if (term_timer_disable_mode_rise) begin
      nxt_s.st = ST_TERM_TIMER_DISABLE_MODE; // see RL9 see RL10
      if (!batt_present_in) begin
        nxt_s.status_on = 1'b0; // see RL11
      end
    end else if (term_timer_disable_mode_fall) begin
      nxt_s.expired = 1'b0;
      if (batt_present_in) begin
        nxt_s.st = start_st; // see RL12 see RL23
      end else begin
        nxt_s.st = ST_DETECT;
        nxt_s.det_after_taper = 1'b0;
        nxt_s.status_on = 1'b0;
      end
    end else if (go) begin
      // low headroom or temperature fault freezes the sequence
      unique case (s_ff.st)
        ST_IDLE: begin
          nxt_s.expired = 1'b0;
          if (batt_above_recharge_in) begin
            nxt_s.st = ST_DETECT; // see RL20
            nxt_s.det_after_taper = 1'b0;
          end else begin
            nxt_s.st = start_st;
          end
        end
        ST_PRECHG: begin
          if (pre_exp) begin
            nxt_s.st = ST_DONE; // see RL13 see RL15
            nxt_s.status_on = 1'b0;
            nxt_s.expired = 1'b1;
          end else if (batt_above_exit_level_in) begin
            nxt_s.st = ST_FAST; // see RL4
          end
        end
        ST_FAST: begin
          if (fast_exp) begin
            nxt_s.st = ST_DONE; // see RL14 see RL15
            nxt_s.status_on = 1'b0;
            nxt_s.expired = 1'b1;
          end else if (taper_done_in && batt_above_recharge_in) begin
            nxt_s.st = ST_DETECT; // see RL17
            nxt_s.det_after_taper = 1'b1;
            nxt_s.status_on = 1'b0;
          end
        end
        ST_DETECT: begin
          if (batt_present_in) begin
            nxt_s.st = s_ff.det_after_taper ? ST_DONE : start_st; // see RL17
          end else begin
            nxt_s.status_on = 1'b0; // see RL18
          end
        end
        ST_TERM_TIMER_DISABLE_MODE: begin
          if (taper_done_in) begin
            nxt_s.status_on = 1'b0; // see RL11
          end
        end
        ST_DONE: begin
          if (!batt_above_recharge_in && !s_ff.expired) begin
            nxt_s.st = start_st; // see RL21 see RL23
          end
        end
        default: begin
          nxt_s.st = ST_IDLE;
        end
      endcase
    end

    // outputs follow the next state
    nxt_s.chg_en = charging(nxt_s.st) && input_present_in && input_headroom_in
                   && !fault && !ts_disable_in && !nxt_s.current_set_latch; // see RL24
    nxt_s.prechg = (nxt_s.st == ST_PRECHG)
                   || (nxt_s.st == ST_TERM_TIMER_DISABLE_MODE && !batt_above_exit_level_in); // see RL4
    nxt_s.half_cur = EXT_TEMP_ZONES && ts_cool_in; // see RL5
    nxt_s.low_vreg = EXT_TEMP_ZONES && ts_warm_in; // see RL6
    nxt_s.term_en = nxt_s.st != ST_TERM_TIMER_DISABLE_MODE; // see RL10
    nxt_s.raise = charging(nxt_s.st) && !raise_exp; // see RL22
    nxt_s.det_run = (nxt_s.st == ST_DETECT) && run; // see RL19
    nxt_s.stat_oe = nxt_s.status_on && input_present_in && input_headroom_in;
    nxt_s.pg_oe = input_present_in && input_headroom_in;
    nxt_s.ilim = ilim_decode(limit_sel_low_in, limit_sel_high_in); // see RL1
    unique case (nxt_s.ilim)
      ILIM_LOW: nxt_s.ilim_ma = `CCC_ILIM_LOW_MA;
      ILIM_HIGH: nxt_s.ilim_ma = `CCC_ILIM_HIGH_MA;
      default: nxt_s.ilim_ma = '0;
    endcase
    nxt_s.term_pct = precharge_term_set_float_in ? `CCC_TERM_DEF_PCT
                                                 : term_pct_in; // see RL3
    nxt_s.pre_pct = {nxt_s.term_pct, 1'b0}; // see RL3
  end

  // ****************************************************
  // state register
  // ****************************************************

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '{st: ST_IDLE, status_on: 1'b1, term_en: 1'b1,
                ilim: ILIM_LOW, term_pct: `CCC_TERM_DEF_PCT,
                pre_pct: {`CCC_TERM_DEF_PCT, 1'b0}, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************

  assign charge_enable_out = s_ff.chg_en;
  assign precharge_out = s_ff.prechg;
  assign half_current_out = s_ff.half_cur;
  assign reduced_vreg_out = s_ff.low_vreg;
  assign term_enable_out = s_ff.term_en;
  assign term_raise_out = s_ff.raise;
  assign term_pct_out = s_ff.term_pct;
  assign precharge_pct_out = s_ff.pre_pct;
  assign ilim_mode_out = s_ff.ilim;
  assign ilim_ma_out = s_ff.ilim_ma;
  assign batt_detect_out = s_ff.det_run;
  assign timer_expired_out = s_ff.expired;
  assign current_set_fault_out = s_ff.current_set_latch;
  assign charge_status_n_oe_out = s_ff.stat_oe; // see RL26
  assign power_good_n_oe_out = s_ff.pg_oe;

  // ****************************************************
  // checks
  // ****************************************************

  default clocking cb @(posedge clock_in);
  endclocking

  default disable iff (!rst_n_in);

  current_set_latch_hold_a: assert property ( // see RL2
    s_ff.current_set_latch && input_present_in |=> s_ff.current_set_latch && !charge_enable_out)
    else $error("current_set latch released while powered");

  prechg_exit_a: assert property ( // see RL4
    s_ff.st == ST_PRECHG && go && !pre_exp && batt_above_exit_level_in
    |=> s_ff.st == ST_FAST)
    else $error("precharge did not move to fast charge");

  cool_half_a: assert property ( // see RL5
    EXT_TEMP_ZONES && ts_cool_in |=> half_current_out)
    else $error("cool zone did not halve current");

  warm_vreg_a: assert property ( // see RL6
    EXT_TEMP_ZONES && ts_warm_in |=> reduced_vreg_out)
    else $error("warm zone did not lower regulation");

  temp_off_a: assert property ( // see RL7
    ts_cold_in || ts_hot_in |=> !charge_enable_out)
    else $error("charging during temperature fault");

  classic_off_a: assert property ( // see RL8
    !EXT_TEMP_ZONES && ts_warm_in |=> !charge_enable_out)
    else $error("classic range charged above window");

  pin_disable_a: assert property ( // see RL9
    ts_disable_in |=> s_ff.st == ST_IDLE && !charge_enable_out && !timer_expired_out)
    else $error("temp_sense low did not disable");

  term_timer_disable_mode_noterm_a: assert property ( // see RL10
    s_ff.st == ST_TERM_TIMER_DISABLE_MODE |-> !term_enable_out)
    else $error("termination active in disable mode");

  expire_release_a: assert property ( // see RL15
    s_ff.st == ST_FAST && go && fast_exp
    |=> s_ff.st == ST_DONE && !s_ff.status_on && !charge_status_n_oe_out
        && timer_expired_out)
    else $error("timer expiry did not end charge");

  refresh_quiet_a: assert property ( // see RL21
    s_ff.st == ST_DONE && !s_ff.status_on && input_present_in && !ts_disable_in
    |=> !s_ff.status_on)
    else $error("refresh charge reasserted status");

  sleep_pause_a: assert property ( // see RL24
    input_present_in && !input_headroom_in && !ts_disable_in && !term_timer_disable_mode_rise
    && !term_timer_disable_mode_fall && !trip |=> $stable(s_ff.st) && !charge_enable_out)
    else $error("sequence moved during low headroom");

endmodule

// file: hdl/ccc_params.svh
// constants of the charge cycle controller
// What this block does
// RL1: three-level pin picks programmed, 100mA or 500mA limit
// RL2: shorted current_set resistor latches charging off
// RL3: precharge is twice termination; float gives 10/20
// RL4: precharge below 2.5V, fast charge above
// RL5: extended zones halve current from 0 to 10C
// RL6: extended zones lower regulation voltage 45 to 60C
// RL7: charging off above 60C or below 0C
// RL8: classic range charges only from 0 to 45C
// RL9: temp_sense low disables, high enters term_timer_disable_mode
// RL10: disable mode resets timer, stops termination, skips detection
// RL11: disable mode releases status on absence or taper
// RL12: leaving disable mode starts new cycle, detects only if battery absent
// RL13: precharge limited to 30 minutes
// RL14: fast charge 10 hours, half rate when limited
// RL15: timer expiry terminates and releases charge status
// RL16: timers reset on disable, power cycle, mode change
// RL17: taper above recharge level releases status, detects, ends
// RL18: missing battery keeps detection running until inserted
// RL19: no detection in disable mode or temperature fault
// RL20: power-up above recharge level runs battery detection
// RL21: drop below recharge level restarts, status stays released
// RL22: termination raised about 14 percent first minute
// RL23: status asserted only during the first charge cycle
// RL24: low input headroom pauses charge and timer
// RL25: timers from one clock via 1000 us tick prescaler
// RL26: analogue crossings arrive as synchronous comparator bits
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// ****************************************************
// timing
// ****************************************************
`define CCC_CLK_MHZ 32'hC8
`define CCC_TICK_US 32'h3E8
`define CCC_US_PER_MIN 32'h0393_8700
`define CCC_MIN_PER_HR 32'h3C
`define CCC_PRECHG_MIN 32'h1E
`define CCC_FAST_HR 32'hA
`define CCC_RAISE_MIN 32'h1

// ****************************************************
// current settings
// ****************************************************
`define CCC_PCT_W 6
`define CCC_TERM_DEF_PCT 6'h0A
`define CCC_MA_W 10
`define CCC_ILIM_LOW_MA 10'h064
`define CCC_ILIM_HIGH_MA 10'h1F4

`endif

// file: hdl/ccc_pkg.sv
// types of the charge cycle controller
package ccc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DETECT = 3'h1,
    ST_PRECHG = 3'h3,
    ST_FAST = 3'h2,
    ST_TERM_TIMER_DISABLE_MODE = 3'h6,
    ST_DONE = 3'h7
  } ccc_state_e;

  typedef enum logic [1:0] {
    ILIM_CURRENT_SET = 2'h0,
    ILIM_LOW = 2'h1,
    ILIM_HIGH = 2'h2
  } ccc_ilim_e;

  typedef struct packed {
    logic [31:0] presc;
    logic skip;
    logic [31:0] ticks;
    logic expired;
  } ccc_tmr_s;

endpackage

// file: hdl/ccc_timer.sv
// prescaled tick timer with half-rate gating
`timescale 1ns/1ps
module ccc_timer #(
  parameter int unsigned PRESC_CYC = 1,
  parameter int unsigned LIMIT = 1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic half_in,
  output logic expired_out
);
  import ccc_pkg::*;

  ccc_tmr_s s_ff;
  ccc_tmr_s nxt_s;
  logic wrap;

  assign wrap = s_ff.presc == 32'(PRESC_CYC - 1);
  assign expired_out = s_ff.expired;

  always_comb begin
    nxt_s = s_ff;
    if (clear_in) begin
      nxt_s = '0;
    end else if (run_in && !s_ff.expired) begin
      nxt_s.presc = wrap ? 32'h0 : s_ff.presc + 32'h1; // see RL25
      if (wrap) begin
        nxt_s.skip = ~s_ff.skip;
        // every other wrap counts while slowed
        if (!half_in || s_ff.skip) begin // see RL14
          nxt_s.ticks = s_ff.ticks + 32'h1;
          nxt_s.expired = s_ff.ticks == 32'(LIMIT - 1);
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  expiry_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_ff.expired && !clear_in |=> s_ff.expired) // see RL15
    else $error("timer expiry dropped without clear");

endmodule

// file: sim/ccc_batt_model.sv
// battery pack, thermistor and host status monitor model
`timescale 1ns/1ps
module ccc_batt_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic charge_enable_in,
  input wire logic inserted_in,
  input wire logic hold_in,
  input wire logic load_in,
  input wire logic [2:0] zone_in,
  input wire logic charge_status_n_oe_in,
  input wire logic power_good_n_oe_in,
  output logic batt_above_exit_level_out,
  output logic batt_above_recharge_out,
  output logic taper_done_out,
  output logic batt_present_out,
  output logic ts_disable_out,
  output logic ts_term_timer_disable_mode_out,
  output logic ts_cold_out,
  output logic ts_cool_out,
  output logic ts_warm_out,
  output logic ts_hot_out,
  output logic charge_status_n_out,
  output logic power_good_n_out
);
  logic [6:0] volt_ff;
  logic present;
  // ****************************************************
  // cell voltage
  // ****************************************************
  // zone 5 means the pack and its thermistor were pulled out
  assign present = inserted_in && (zone_in != 3'h5);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      volt_ff <= 7'h00;
    end else if (load_in) begin
      volt_ff <= (volt_ff > 7'h04) ? volt_ff - 7'h04 : 7'h00;
    end else if (charge_enable_in && present && !hold_in && volt_ff < 7'h46) begin
      volt_ff <= volt_ff + 7'h04;
    end
  end
  // ****************************************************
  // comparator bits and pins
  // ****************************************************
  assign batt_above_exit_level_out = present && (volt_ff >= 7'h14);
  assign batt_above_recharge_out = present && (volt_ff >= 7'h3C);
  assign taper_done_out = present && (volt_ff >= 7'h46);
  assign batt_present_out = present;
  assign ts_disable_out = (zone_in == 3'h6);
  assign ts_term_timer_disable_mode_out = (zone_in == 3'h5);
  assign ts_cold_out = (zone_in == 3'h1);
  assign ts_cool_out = (zone_in == 3'h2);
  assign ts_warm_out = (zone_in == 3'h3);
  assign ts_hot_out = (zone_in == 3'h4);
  // pull-ups on both status lines
  assign charge_status_n_out = charge_status_n_oe_in ? 1'b0 : 1'b1;
  assign power_good_n_out = power_good_n_oe_in ? 1'b0 : 1'b1;
endmodule

// file: sim/testbench.sv
// self-checking bench of the charge cycle controller
`timescale 1ns/1ps
`include "ccc_params.svh"
`define CHK(a, b) check_val(64'(a), 64'(b));
module testbench;
  import ccc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic in_ok, headroom, lim_low, lim_high, current_set_short, cur_min, pt_float;
  logic [5:0] term_pct;
  logic inserted, hold, load, thermal, ivpm, usb;
  logic [2:0] zone;
  logic above_exit, above_rch, taper, present, ts_dis, ts_term_timer_disable_mode, ts_cold, ts_cool, ts_warm, ts_hot;
  logic charge_enable, precharge, half, reduced, term_enable, term_raise, batt_detect;
  logic timer_expired, current_set_fault, status_oe, pg_oe, status_pin, pg_pin;
  logic [5:0] term_pct_o;
  logic [6:0] pre_pct;
  ccc_ilim_e ilim_mode;
  logic [9:0] ilim_ma;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [2:0] zt [4] = '{3'h2, 3'h3, 3'h1, 3'h4};
  // ****************************************************
  // clock, watchdog, instances
  // ****************************************************
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end
  ccc_charge_ctrl #(.TICK_CYC(4), .MIN_TICKS(8), .PRE_TICKS(8), .FAST_TICKS(16),
    .RAISE_TICKS(2)) dut_u (
    .clock_in(clock), .rst_n_in(rst_n), .input_present_in(in_ok),
    .input_headroom_in(headroom), .limit_sel_low_in(lim_low), .limit_sel_high_in(lim_high),
    .current_set_short_in(current_set_short), .out_current_min_in(cur_min),
    .precharge_term_set_float_in(pt_float), .term_pct_in(term_pct),
    .batt_above_exit_level_in(above_exit), .batt_above_recharge_in(above_rch),
    .taper_done_in(taper), .batt_present_in(present), .ts_disable_in(ts_dis),
    .ts_term_timer_disable_mode_in(ts_term_timer_disable_mode), .ts_cold_in(ts_cold), .ts_cool_in(ts_cool), .ts_warm_in(ts_warm),
    .ts_hot_in(ts_hot), .thermal_reg_in(thermal), .input_voltage_power_mgmt_in(ivpm),
    .usb_limit_in(usb), .charge_enable_out(charge_enable), .precharge_out(precharge),
    .half_current_out(half), .reduced_vreg_out(reduced), .term_enable_out(term_enable),
    .term_raise_out(term_raise), .term_pct_out(term_pct_o), .precharge_pct_out(pre_pct),
    .ilim_mode_out(ilim_mode), .ilim_ma_out(ilim_ma), .batt_detect_out(batt_detect),
    .timer_expired_out(timer_expired), .current_set_fault_out(current_set_fault),
    .charge_status_n_oe_out(status_oe), .power_good_n_oe_out(pg_oe));
  ccc_batt_model model_u (
    .clock_in(clock), .rst_n_in(rst_n), .charge_enable_in(charge_enable),
    .inserted_in(inserted), .hold_in(hold), .load_in(load), .zone_in(zone),
    .charge_status_n_oe_in(status_oe), .power_good_n_oe_in(pg_oe),
    .batt_above_exit_level_out(above_exit), .batt_above_recharge_out(above_rch),
    .taper_done_out(taper), .batt_present_out(present), .ts_disable_out(ts_dis),
    .ts_term_timer_disable_mode_out(ts_term_timer_disable_mode), .ts_cold_out(ts_cold), .ts_cool_out(ts_cool),
    .ts_warm_out(ts_warm), .ts_hot_out(ts_hot), .charge_status_n_out(status_pin),
    .power_good_n_out(pg_pin));
  // ****************************************************
  // helper tasks
  // ****************************************************
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = charge_enable;
      1: pick = precharge;
      2: pick = batt_detect;
      3: pick = timer_expired;
      4: pick = term_raise;
      5: pick = above_rch;
      default: pick = above_exit;
    endcase
  endfunction
  // bounded wait, cycle count returned in k
  task automatic wait_for(input int sel, input logic val, output int k);
    k = 0;
    while (pick(sel) !== val && k < 400) begin
      @(negedge clock);
      k++;
    end
    if (k >= 400) begin
      errors++;
      $display("[ERR] t=%0t waited on %h for %h", $time, sel, val);
    end
  endtask
  // host disable, drain cell, then fresh charge cycle
  task automatic restart(input logic h);
    int k;
    zone = 3'h6;
    load = 1'b1;
    cyc(2);
    wait_for(6, 1'b0, k);
    load = 1'b0;
    hold = h;
    zone = 3'h0;
    cyc(2);
  endtask
  task automatic test_end(input string name);
    $display("test %s done, checks %0d", name, total_checks);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    in_ok = 1'b0;
    headroom = 1'b0;
    lim_low = 1'b1;
    lim_high = 1'b0;
    current_set_short = 1'b0;
    cur_min = 1'b0;
    pt_float = 1'b1;
    term_pct = 6'h0F;
    inserted = 1'b1;
    hold = 1'b1;
    load = 1'b0;
    zone = 3'h0;
    thermal = 1'b0;
    ivpm = 1'b0;
    usb = 1'b0;
    cyc(10);
    `CHK(status_oe, 1'b0)
    `CHK(term_enable, 1'b1)
    `CHK(ilim_mode, ILIM_LOW)
    `CHK(pre_pct, 7'h14)
    rst_n = 1'b1;
    test_end("reset");
    in_ok = 1'b1;
    headroom = 1'b1;
    cyc(2);
    `CHK(charge_enable, 1'b1)
    `CHK(precharge, 1'b1)
    `CHK(status_pin, 1'b0)
    `CHK(pg_pin, 1'b0)
    for (int i = 0; i < 3; i++) begin
      lim_low = (i == 0);
      lim_high = (i == 2);
      cyc(2);
      `CHK(ilim_mode, i)
      `CHK(ilim_ma, (i == 0) ? 0 : (i == 1) ? `CCC_ILIM_LOW_MA : `CCC_ILIM_HIGH_MA)
    end
    `CHK(term_pct_o, `CCC_TERM_DEF_PCT)
    pt_float = 1'b0;
    cyc(2);
    `CHK(term_pct_o, 6'h0F)
    `CHK(pre_pct, 7'h1E)
    pt_float = 1'b1;
    test_end("power-up and limits");
    hold = 1'b0;
    wait_for(1, 1'b0, n);
    `CHK(above_exit, 1'b1)
    wait_for(2, 1'b1, n);
    `CHK(status_pin, 1'b1)
    wait_for(2, 1'b0, n);
    `CHK(charge_enable, 1'b0)
    `CHK(timer_expired, 1'b0)
    load = 1'b1;
    wait_for(5, 1'b0, n);
    load = 1'b0;
    wait_for(0, 1'b1, n);
    `CHK(status_pin, 1'b1)
    cyc(4);
    `CHK(status_pin, 1'b1)
    test_end("termination and refresh");
    zone = 3'h6;
    cyc(3);
    `CHK(charge_enable, 1'b0)
    restart(1'b1);
    `CHK(status_pin, 1'b0)
    `CHK(term_raise, 1'b1)
    wait_for(4, 1'b0, n);
    `CHK(n <= 8, 1'b1)
    for (int i = 0; i < 4; i++) begin
      zone = zt[i];
      cyc(2);
      `CHK(charge_enable, i < 2)
      if (i == 0) `CHK(half, 1'b1)
      if (i == 1) `CHK(reduced, 1'b1)
    end
    zone = 3'h0;
    cyc(2);
    `CHK(charge_enable, 1'b1)
    test_end("temperature");
    restart(1'b1);
    wait_for(3, 1'b1, n);
    `CHK(n >= 26 && n <= 36, 1'b1)
    `CHK(status_pin, 1'b1)
    `CHK(charge_enable, 1'b0)
    restart(1'b0);
    wait_for(1, 1'b0, n);
    hold = 1'b1;
    usb = 1'b1;
    wait_for(3, 1'b1, n);
    `CHK(n >= 112 && n <= 136, 1'b1)
    `CHK(status_pin, 1'b1)
    usb = 1'b0;
    test_end("timers");
    restart(1'b1);
    current_set_short = 1'b1;
    cyc(3);
    `CHK(current_set_fault, 1'b0)
    cur_min = 1'b1;
    cyc(3);
    `CHK(current_set_fault, 1'b1)
    `CHK(charge_enable, 1'b0)
    current_set_short = 1'b0;
    cur_min = 1'b0;
    zone = 3'h6;
    cyc(2);
    zone = 3'h0;
    cyc(3);
    `CHK(current_set_fault, 1'b1)
    in_ok = 1'b0;
    cyc(3);
    in_ok = 1'b1;
    cyc(3);
    `CHK(current_set_fault, 1'b0)
    `CHK(charge_enable, 1'b1)
    headroom = 1'b0;
    cyc(3);
    `CHK(charge_enable, 1'b0)
    headroom = 1'b1;
    cyc(3);
    `CHK(charge_enable, 1'b1)
    test_end("short latch and sleep");
    zone = 3'h5;
    cyc(3);
    `CHK(term_enable, 1'b0)
    `CHK(status_pin, 1'b1)
    `CHK(batt_detect, 1'b0)
    zone = 3'h0;
    cyc(2);
    `CHK(charge_enable, 1'b1)
    `CHK(precharge, 1'b1)
    `CHK(term_enable, 1'b1)
    `CHK(status_pin, 1'b1)
    test_end("disable mode");
    results();
  end
endmodule
